// ### rtl/lcfg_regs.svh
// Register offsets, field positions, reset values, decode values and LCD clock frequency of the LCD config bank
`ifndef LCFG_REGS_SVH
`define LCFG_REGS_SVH
`define LCFG_OFF_CLKSEL   4'h0
`define LCFG_OFF_SUPPLY   4'h1
`define LCFG_OFF_CTRL1    4'h2
`define LCFG_OFF_CTRL0    4'h3
`define LCFG_OFF_BLINK    4'h4
`define LCFG_OFF_FPEN0    4'h5
`define LCFG_OFF_STATUS   4'hB
`define LCFG_OFF_MASK     4'hC
`define LCFG_NUM_FPEN     6
`define LCFG_CLK_SRC_BIT  7
`define LCFG_PRESCALE_BY_SIXTEEN_BIT    6
`define LCFG_PUMP_EN_BIT  7
`define LCFG_PUMP_MS_BIT  6
`define LCFG_HDRV_BIT     5
`define LCFG_BYPASS_BIT   2
`define LCFG_IRQ_EN_BIT   7
`define LCFG_WAIT_BIT     1
`define LCFG_STOP3_BIT    0
`define LCFG_EN_BIT       7
`define LCFG_LPW_BIT      6
`define LCFG_BLKALL_BIT   7
`define LCFG_RST_CLKSEL   8'h00
`define LCFG_RST_SUPPLY   8'h03
`define LCFG_RST_CTRL1    8'h00
`define LCFG_RST_CTRL0    8'h03
`define LCFG_RST_BLINK    8'h00
`define LCFG_RST_FPEN     8'h00
`define LCFG_SUPPLY_EXT   2'h2
`define LCFG_DUTY_QUARTER 2'h3
`define LCFG_LCDCLK_HZ    32768
`endif

// ### rtl/lcfg_pkg.sv
// Types shared by the LCD configuration bank
package lcfg_pkg;
  typedef enum logic [1:0] {
    LCFG_IDLE = 2'b00,
    LCFG_ACK  = 2'b01
  } lcfg_bus_t;
endpackage

// ### rtl/lcfg_bank.sv
// LCD driver configuration register bank with Avalon-MM slave
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "lcfg_regs.svh"
module lcfg_bank
  import lcfg_pkg::*;
#(
  parameter int NUM_FP = 41
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [1:0]        avs_response,
  input  wire logic              frame_tick,
  input  wire logic              cpu_wait,
  input  wire logic              cpu_stop3,
  output logic                   lcd_clk_from_bus,
  output logic                   prescale_by_sixteen,
  output logic      [5:0]        clk_adjust,
  output logic                   pump_enable,
  output logic                   pump_multiplier_sel,
  output logic                   high_drive_buffer,
  output logic      [1:0]        pump_clock_adjust,
  output logic                   buffer_bypass,
  output logic      [1:0]        supply_select,
  output logic                   external_panel_supply,
  output logic                   low_power_waveform,
  output logic      [1:0]        duty_select,
  output logic                   quarter_duty,
  output logic      [2:0]        frame_rate_select,
  output logic                   blink_all_select,
  output logic      [2:0]        blink_rate,
  output logic                   module_enable,
  output logic                   display_active,
  output logic      [NUM_FP-1:0] frontplane_drive,
  output logic                   irq
);

  logic [7:0]  clksel_r;
  logic [7:0]  supply_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl0_r;
  logic [7:0]  blink_r;
  logic [7:0]  fpen_r [`LCFG_NUM_FPEN];
  logic        flag_r;
  logic        mask_r;
  lcfg_bus_t   bus_r;
  logic        req;
  logic        wr_ok;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [47:0] fp_flat;

  assign req    = (avs_read || avs_write) && bus_r == LCFG_IDLE;
  assign mapped = avs_address <= `LCFG_OFF_MASK;
  assign wr_ok  = clk_en && req && avs_write && avs_byteenable[0];

  // One wait state per access, then acknowledge
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_r <= LCFG_IDLE;
    else if (clk_en)
    begin
      if (req)
        bus_r <= LCFG_ACK;
      else
        bus_r <= LCFG_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if (clk_en)
      avs_waitrequest <= ~req;
  end

  // Clock select register, byte lane 0
  always_ff @(posedge clk)
  begin
    if (rst)
      clksel_r <= `LCFG_RST_CLKSEL;
    else if (wr_ok && avs_address == `LCFG_OFF_CLKSEL)
      clksel_r <= avs_writedata[7:0];
  end

  // Supply control register
  always_ff @(posedge clk)
  begin
    if (rst)
      supply_r <= `LCFG_RST_SUPPLY;
    else if (wr_ok && avs_address == `LCFG_OFF_SUPPLY)
      supply_r <= avs_writedata[7:0];
  end

  // Control one register
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl1_r <= `LCFG_RST_CTRL1;
    else if (wr_ok && avs_address == `LCFG_OFF_CTRL1)
      ctrl1_r <= avs_writedata[7:0];
  end

  // Control zero register
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl0_r <= `LCFG_RST_CTRL0;
    else if (wr_ok && avs_address == `LCFG_OFF_CTRL0)
      ctrl0_r <= avs_writedata[7:0];
  end

  // Blink control register
  always_ff @(posedge clk)
  begin
    if (rst)
      blink_r <= `LCFG_RST_BLINK;
    else if (wr_ok && avs_address == `LCFG_OFF_BLINK)
      blink_r <= avs_writedata[7:0];
  end

  // Interrupt mask bit
  always_ff @(posedge clk)
  begin
    if (rst)
      mask_r <= 1'b0;
    else if (wr_ok && avs_address == `LCFG_OFF_MASK)
      mask_r <= avs_writedata[0];
  end

  // Frontplane enable registers
  genvar g;
  generate
    for (g = 0; g < `LCFG_NUM_FPEN; g++)
    begin : g_fpen
      always_ff @(posedge clk)
      begin
        if (rst)
          fpen_r[g] <= `LCFG_RST_FPEN;
        else if (wr_ok && avs_address == `LCFG_OFF_FPEN0 + 4'(g))
          fpen_r[g] <= avs_writedata[7:0];
      end
      assign fp_flat[g*8 +: 8] = fpen_r[g];
    end
  endgenerate

  // Frame flag: set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (clk_en)
    begin
      if (frame_tick)
        flag_r <= 1'b1;
      else if (wr_ok && avs_address == `LCFG_OFF_STATUS && avs_writedata[0])
        flag_r <= 1'b0;
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    case (avs_address)
      `LCFG_OFF_CLKSEL: rd_byte = clksel_r;
      `LCFG_OFF_SUPPLY: rd_byte = supply_r;
      `LCFG_OFF_CTRL1:  rd_byte = ctrl1_r;
      `LCFG_OFF_CTRL0:  rd_byte = ctrl0_r;
      `LCFG_OFF_BLINK:  rd_byte = blink_r;
      `LCFG_OFF_STATUS: rd_byte = {7'h00, flag_r};
      `LCFG_OFF_MASK:   rd_byte = {7'h00, mask_r};
      default:
      begin
        if (avs_address >= `LCFG_OFF_FPEN0 && avs_address < `LCFG_OFF_STATUS)
          rd_byte = fpen_r[3'(avs_address - `LCFG_OFF_FPEN0)];
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end
    else if (clk_en && req)
    begin
      avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      avs_response <= mapped ? 2'h0 : 2'h3;
    end
  end

  // Clock source and scaling outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lcd_clk_from_bus    <= 1'b0;
      prescale_by_sixteen <= 1'b0;
      clk_adjust          <= 6'h00;
    end
    else if (clk_en)
    begin
      lcd_clk_from_bus    <= clksel_r[`LCFG_CLK_SRC_BIT];
      prescale_by_sixteen <= clksel_r[`LCFG_PRESCALE_BY_SIXTEEN_BIT];
      clk_adjust          <= clksel_r[5:0];
    end
  end

  // Charge pump and supply outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pump_enable           <= 1'b0;
      pump_multiplier_sel   <= 1'b0;
      high_drive_buffer     <= 1'b0;
      pump_clock_adjust     <= 2'h0;
      buffer_bypass         <= 1'b0;
      supply_select         <= 2'h3;
      external_panel_supply <= 1'b0;
    end
    else if (clk_en)
    begin
      pump_enable           <= supply_r[`LCFG_PUMP_EN_BIT];
      pump_multiplier_sel   <= supply_r[`LCFG_PUMP_MS_BIT];
      high_drive_buffer     <= supply_r[`LCFG_HDRV_BIT];
      pump_clock_adjust     <= supply_r[4:3];
      buffer_bypass         <= supply_r[`LCFG_BYPASS_BIT];
      supply_select         <= supply_r[1:0];
      external_panel_supply <= supply_r[1:0] == `LCFG_SUPPLY_EXT;
    end
  end

  // Duty, waveform and frame rate outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_power_waveform <= 1'b0;
      duty_select        <= `LCFG_DUTY_QUARTER;
      quarter_duty       <= 1'b1;
      frame_rate_select  <= 3'h0;
    end
    else if (clk_en)
    begin
      low_power_waveform <= ctrl0_r[`LCFG_LPW_BIT];
      duty_select        <= ctrl0_r[1:0];
      quarter_duty       <= ctrl0_r[1:0] == `LCFG_DUTY_QUARTER;
      frame_rate_select  <= ctrl0_r[5:3];
    end
  end

  // Blink outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      blink_all_select <= 1'b0;
      blink_rate       <= 3'h0;
    end
    else if (clk_en)
    begin
      blink_all_select <= blink_r[`LCFG_BLKALL_BIT];
      blink_rate       <= blink_r[2:0];
    end
  end

  // Module enable output
  always_ff @(posedge clk)
  begin
    if (rst)
      module_enable <= 1'b0;
    else if (clk_en)
      module_enable <= ctrl0_r[`LCFG_EN_BIT];
  end

  // Display drive gated by enable and low-power modes
  always_ff @(posedge clk)
  begin
    if (rst)
      display_active <= 1'b0;
    else if (clk_en)
      display_active <= ctrl0_r[`LCFG_EN_BIT]
                        && !(cpu_wait && ctrl1_r[`LCFG_WAIT_BIT])
                        && !(cpu_stop3 && ctrl1_r[`LCFG_STOP3_BIT]);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      frontplane_drive <= '0;
    else if (clk_en)
      frontplane_drive <= fp_flat[NUM_FP-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= flag_r && (ctrl1_r[`LCFG_IRQ_EN_BIT] || mask_r);
  end

endmodule

// ### tb/lcfg_bank_properties.sv
// Property checker for the LCD config bank ports
`timescale 1ns/1ps
module lcfg_bank_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [1:0] supply_select,
  input wire logic       external_panel_supply,
  input wire logic [1:0] duty_select,
  input wire logic       quarter_duty,
  input wire logic       module_enable,
  input wire logic       display_active,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ext;
    external_panel_supply == (supply_select == 2'h2);
  endproperty
  a_ext: assert property (p_ext) else $error("supply decode");
  property p_quarter;
    quarter_duty == (duty_select == 2'h3);
  endproperty
  a_quarter: assert property (p_quarter) else $error("duty decode");
  property p_disp;
    display_active |-> module_enable;
  endproperty
  a_disp: assert property (p_disp) else $error("display without enable");
  property p_ack_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("long ack");
  property p_ack_soon;
    (avs_read || avs_write) |-> ##[0:8] !avs_waitrequest;
  endproperty
  a_ack_soon: assert property (p_ack_soon) else $error("no ack");
  property p_idle;
    !(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("ack while idle");
  property p_unmapped;
    !avs_waitrequest |-> avs_response == ((avs_address > 4'hC) ? 2'h3 : 2'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("response code");
  property p_irq_hold;
    $fell(irq) |-> ($past(avs_write) || $past(avs_write, 2));
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule
bind lcfg_bank lcfg_bank_properties lcfg_bank_properties_inst (
  .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .avs_response,
  .supply_select, .external_panel_supply, .duty_select, .quarter_duty,
  .module_enable, .display_active, .irq
);

// ### tb/lcfg_panel.sv
// Glass panel model: frame events and count of driven frontplanes
`timescale 1ns/1ps
module lcfg_panel #(
  parameter int LEN = 16
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        run,
  input wire logic        display_active,
  input wire logic [40:0] frontplane_drive,
  output logic            frame_tick,
  output logic [5:0]      lit_count
);
  logic [7:0] cnt_r;
  // One pulse at the end of each frame while running
  always_ff @(posedge clk)
  begin
    cnt_r      <= (rst || !run || cnt_r == 8'(LEN - 1)) ? 8'h00 : cnt_r + 8'h01;
    frame_tick <= !rst && run && cnt_r == 8'(LEN - 1);
  end
  assign lit_count = display_active ? 6'($countones(frontplane_drive)) : 6'h00;
endmodule

// ### tb/tb_lcfg_bank.sv
// Self-checking bench for the LCD config bank
`timescale 1ns/1ps
module tb_lcfg_bank;
  logic        clk = 0, rst = 1, clk_en = 1, avs_read = 0, avs_write = 0, run = 0;
  logic        cpu_wait = 0, cpu_stop3 = 0, avs_waitrequest, frame_tick, irq;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [1:0]  avs_response, r, supply_select, duty_select, pump_clock_adjust;
  logic [2:0]  frame_rate_select, blink_rate;
  logic [5:0]  clk_adjust, lit_count;
  logic [40:0] frontplane_drive;
  logic        lcd_clk_from_bus, prescale_by_sixteen, pump_enable, pump_multiplier_sel;
  logic        high_drive_buffer, buffer_bypass, external_panel_supply, low_power_waveform;
  logic        quarter_duty, blink_all_select, module_enable, display_active;
  int          failures = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  lcfg_bank lcfg_bank_inst (.clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .frame_tick, .cpu_wait, .cpu_stop3, .lcd_clk_from_bus, .prescale_by_sixteen,
    .clk_adjust, .pump_enable, .pump_multiplier_sel, .high_drive_buffer,
    .pump_clock_adjust, .buffer_bypass, .supply_select, .external_panel_supply,
    .low_power_waveform, .duty_select, .quarter_duty, .frame_rate_select,
    .blink_all_select, .blink_rate, .module_enable, .display_active,
    .frontplane_drive, .irq);
  lcfg_panel lcfg_panel_inst (.clk, .rst, .run, .display_active, .frontplane_drive,
    .frame_tick, .lit_count);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge, then releases
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do
    begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, 4'h0);
    chk({q[29:0], r}, {22'h0, e, 2'h0});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #50000;
    failures++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(32'({module_enable, display_active, quarter_duty, irq, lcd_clk_from_bus}), 32'h4);
    for (int i = 0; i < 11; i++)
    begin
      rd(4'(i), (i == 1 || i == 3) ? 8'h03 : 8'h00);
      wr(4'(i), 8'h5A ^ 8'(i));
      rd(4'(i), 8'h5A ^ 8'(i));
      wr(4'(i), 8'h00);
    end
    wr(4'h0, 8'hC2);
    chk(32'({lcd_clk_from_bus, prescale_by_sixteen, clk_adjust}), 32'hC2);
    wr(4'h1, 8'hF6);
    chk(32'({pump_enable, pump_multiplier_sel, high_drive_buffer, pump_clock_adjust,
             buffer_bypass, supply_select}), 32'hF6);
    chk(32'(external_panel_supply), 32'h1);
    wr(4'h3, 8'h2B);
    chk(32'({low_power_waveform, frame_rate_select, quarter_duty}), 32'hB);
    wr(4'h4, 8'h85);
    chk(32'({blink_all_select, blink_rate}), 32'hD);
    wr(4'h5, 8'hFF);
    wr(4'hA, 8'h01);
    chk({frontplane_drive[40:32], frontplane_drive[22:0]}, {9'h100, 23'hFF});
    wr(4'h3, 8'hAB);
    chk(32'({module_enable, lit_count}), 32'h49);
    cpu_wait <= 1;
    wr(4'h2, 8'h02);
    chk(32'(display_active), 32'h0);
    wr(4'h2, 8'h00);
    chk(32'(display_active), 32'h1);
    cpu_wait <= 0;
    cpu_stop3 <= 1;
    wr(4'h2, 8'h01);
    chk(32'(display_active), 32'h0);
    wr(4'h2, 8'h00);
    chk(32'(display_active), 32'h1);
    wr(4'h1, 8'h01);
    chk(32'({pump_enable, external_panel_supply}), 32'h0);
    run <= 1;
    repeat (20) @(posedge clk);
    run <= 0;
    rd(4'hB, 8'h01);
    chk(32'(irq), 32'h0);
    wr(4'hC, 8'h01);
    chk(32'(irq), 32'h1);
    wr(4'hC, 8'h00);
    wr(4'h2, 8'h80);
    chk(32'(irq), 32'h1);
    wr(4'hB, 8'h01);
    rd(4'hB, 8'h00);
    chk(32'(irq), 32'h0);
    xfer(1'b0, 4'hF, 8'h00, 4'h0);
    chk({q[29:0], r}, 32'h3);
    xfer(1'b1, 4'h4, 8'h00, 4'h0);
    clk_en <= 0;
    repeat (3) @(posedge clk);
    clk_en <= 1;
    rd(4'h4, 8'h85);
    results();
  end
endmodule
